// ---- hdl/dswp_packer.sv ----
/*
 * Drive status word packer: builds the first cyclic status word and the
 * torque setpoint process word that the drive returns to its motion
 * controller once per communication cycle.
 * Assumes all inputs are synchronous to MCLK, that CYCLE_TICK pulses once
 * per communication cycle, and that SYS_RST is the drive's initialization.
 */

`timescale 1ns/1ps
module dswp_packer (
  input wire logic MCLK, // System clock, 40 MHz.
  input wire logic SYS_RST, // Synchronous reset, active high.
  input wire logic CYCLE_TICK, // One pulse per communication cycle.
  input wire dswp_pkg::dswp_cond_t DRIVE_COND, // Drive condition levels.
  input wire dswp_pkg::dswp_speed_t SPEED, // Speed values and limits.
  input wire logic signed [15:0] TORQUE_SETPOINT, // Torque setpoint, internal units.
  input wire logic [15:0] TORQUE_REFERENCE_QUANTITY, // Torque for 100 percent.
  output logic [15:0] STATUS_WORD, // First status word.
  output logic STATUS_VALID, // Pulse: status word refreshed.
  output logic [15:0] TORQUE_SETPOINT_WORD, // Normalized torque word.
  output logic [4:0] TORQUE_WORD_SLOT, // Process-data slot of torque word.
  output logic TORQUE_VALID // Pulse: torque word refreshed.
);
  import dswp_pkg::*;

  typedef struct packed {
    dswp_drive_state_t drive_state;
    logic [15:0] status_word;
    logic status_valid;
    logic [15:0] torque_word;
    logic [4:0] torque_slot;
    logic torque_valid;
    logic torque_neg;
    logic div_start;
  } dswp_state_t;

  dswp_state_t s;
  dswp_state_t next_s;

  logic div_busy;
  logic div_done;
  logic [DIV_W-1:0] div_quotient;
  logic [DIV_W-1:0] div_dividend;
  logic [DIV_W-1:0] div_divisor;

  // ===========================================================================
  // Speed evaluation
  // ===========================================================================
  logic signed [16:0] speed_diff;
  logic [16:0] speed_dev;
  logic [16:0] speed_mag;
  logic speed_in_tol;
  logic speed_cmp_reached;
  logic speed_non_neg;

  always_comb begin
    speed_diff = 17'(SPEED.setpoint) - 17'(SPEED.actual);
    speed_dev = speed_diff[16] ? 17'(-speed_diff) : 17'(speed_diff);
    speed_mag = SPEED.actual[15] ? 17'(-17'(SPEED.actual)) : 17'(SPEED.actual);
    speed_in_tol = speed_dev <= {1'b0, SPEED.tolerance};
    speed_cmp_reached = speed_mag >= {1'b0, SPEED.compare_level};
    speed_non_neg = ~SPEED.actual[15];
  end

  // ===========================================================================
  // Torque magnitude and divider operands
  // ===========================================================================
  logic [16:0] torque_mag;

  always_comb begin
    torque_mag = TORQUE_SETPOINT[15] ? 17'(-17'(TORQUE_SETPOINT)) : 17'(TORQUE_SETPOINT);
    // Magnitude times 2^14 over the reference keeps full scale at 16'h4000.
    div_dividend = DIV_W'({torque_mag, {NORM_SHIFT{1'b0}}});
    div_divisor = DIV_W'(TORQUE_REFERENCE_QUANTITY);
  end

  dswp_divider #(
    .W(DIV_W),
    .STEPS(DIV_STEPS)
  ) u_div (
    .clk(MCLK),
    .rst(SYS_RST),
    .start(s.div_start),
    .dividend(div_dividend),
    .divisor(div_divisor),
    .busy(div_busy),
    .done(div_done),
    .quotient(div_quotient)
  );

  // ===========================================================================
  // Drive state sequence
  // ===========================================================================
  logic stop_active;
  logic [15:0] status_bits;
  logic [15:0] torque_scaled;

  always_comb begin
    stop_active = DRIVE_COND.coast_stop_request | DRIVE_COND.quick_stop_request;
    next_s = s;
    next_s.status_valid = 1'b0;
    next_s.torque_valid = 1'b0;
    next_s.div_start = 1'b0;
    next_s.torque_slot = TORQUE_SLOT;

    case (s.drive_state)
      DS_INIT: begin
        if (DRIVE_COND.supply_on && DRIVE_COND.electronics_ready) begin
          next_s.drive_state = DS_INHIBIT;
        end
      end
      DS_INHIBIT: begin
        // Leaving inhibit needs the stop command first, then switch-on.
        if (DRIVE_COND.normal_stop_command && !stop_active) begin
          next_s.drive_state = DS_READY_ON;
        end
      end
      DS_READY_ON: begin
        if (stop_active) begin
          next_s.drive_state = DS_INHIBIT;
        end else if (DRIVE_COND.switch_on_command && !DRIVE_COND.normal_stop_command) begin
          next_s.drive_state = DS_SWITCHED_ON;
        end
      end
      DS_SWITCHED_ON: begin
        if (stop_active) begin
          next_s.drive_state = DS_INHIBIT;
        end else if (DRIVE_COND.normal_stop_command) begin
          next_s.drive_state = DS_READY_ON;
        end else if (DRIVE_COND.pulses_enabled && DRIVE_COND.line_voltage) begin
          next_s.drive_state = DS_OPERATION;
        end
      end
      DS_OPERATION: begin
        if (stop_active) begin
          next_s.drive_state = DS_INHIBIT;
        end else if (DRIVE_COND.normal_stop_command) begin
          next_s.drive_state = DS_READY_ON;
        end else if (!DRIVE_COND.pulses_enabled) begin
          next_s.drive_state = DS_SWITCHED_ON;
        end
      end
      DS_FAULT: begin
        // An acknowledged fault with its cause gone lands in inhibit.
        if (DRIVE_COND.fault_ack && !DRIVE_COND.fault_active) begin
          next_s.drive_state = DS_INHIBIT;
        end
      end
      default: begin
        next_s.drive_state = DS_INIT;
      end
    endcase

    // A fault overrides every other state except init.
    if (DRIVE_COND.fault_active && s.drive_state != DS_INIT) begin
      next_s.drive_state = DS_FAULT;
    end
    if (!DRIVE_COND.supply_on || !DRIVE_COND.electronics_ready) begin
      next_s.drive_state = DS_INIT;
    end

    // Status bits, taken from the conditions of the current clock.
    status_bits = STATUS_RESET;
    status_bits[BIT_READY_SWITCH_ON] = DRIVE_COND.supply_on
        & DRIVE_COND.electronics_ready;
    status_bits[BIT_READY] = DRIVE_COND.line_voltage;
    status_bits[BIT_OPERATION_ENABLED] = (s.drive_state == DS_OPERATION)
        & DRIVE_COND.electronics_ready & DRIVE_COND.pulses_enabled
        & DRIVE_COND.at_setpoint;
    status_bits[BIT_FAULT] = (s.drive_state == DS_FAULT);
    status_bits[BIT_NO_COAST_STOP] = ~DRIVE_COND.coast_stop_request;
    status_bits[BIT_NO_QUICK_STOP] = ~DRIVE_COND.quick_stop_request;
    status_bits[BIT_POWER_ON_INHIBIT] = (s.drive_state == DS_INHIBIT);
    status_bits[BIT_ALARM] = DRIVE_COND.alarm_pending;
    status_bits[BIT_SPEED_IN_TOL] = speed_in_tol;
    status_bits[BIT_CONTROL_REQUEST] = DRIVE_COND.control_request;
    status_bits[BIT_COMPARE_REACHED] = speed_cmp_reached;
    status_bits[BIT_LIMIT_REACHED] = DRIVE_COND.limit_reached;
    status_bits[BIT_BRAKE_OPEN] = DRIVE_COND.brake_open_command;
    status_bits[BIT_MOTOR_OVERTEMP] = DRIVE_COND.motor_overtemp_alarm;
    status_bits[BIT_SPEED_NON_NEG] = speed_non_neg;
    status_bits[BIT_CONVERTER_OVERLOAD] = DRIVE_COND.converter_overload_alarm;

    // The whole word is refreshed on each cycle tick, bit 0 as LSB.
    if (CYCLE_TICK) begin
      next_s.status_word = status_bits;
      next_s.status_valid = 1'b1;
      // A tick during a running division starts no new one; the running division still writes its word.
      if (!div_busy && !s.div_start) begin
        next_s.div_start = 1'b1;
        next_s.torque_neg = TORQUE_SETPOINT[15];
      end
    end

    // Saturate to the signed word range, then restore the sign.
    torque_scaled = TORQUE_RESET;
    if (s.torque_neg) begin
      if (div_quotient > DIV_W'(TORQUE_SAT_NEG)) begin
        torque_scaled = TORQUE_SAT_NEG;
      end else begin
        torque_scaled = 16'(-div_quotient[15:0]);
      end
    end else begin
      if (div_quotient > DIV_W'(TORQUE_SAT_POS)) begin
        torque_scaled = TORQUE_SAT_POS;
      end else begin
        torque_scaled = div_quotient[15:0];
      end
    end

    if (div_done) begin
      next_s.torque_word = torque_scaled;
      next_s.torque_valid = 1'b1;
    end
  end

  // ===========================================================================
  // State register
  // ===========================================================================
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      s.drive_state <= DS_INIT;
      s.status_word <= STATUS_RESET;
      s.status_valid <= 1'b0;
      s.torque_word <= TORQUE_RESET;
      s.torque_slot <= TORQUE_SLOT;
      s.torque_valid <= 1'b0;
      s.torque_neg <= 1'b0;
      s.div_start <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  assign STATUS_WORD = s.status_word;
  assign STATUS_VALID = s.status_valid;
  assign TORQUE_SETPOINT_WORD = s.torque_word;
  assign TORQUE_WORD_SLOT = s.torque_slot;
  assign TORQUE_VALID = s.torque_valid;

endmodule // dswp_packer

// ---- hdl/dswp_pkg.sv ----
/*
 * Shared constants and carrier types of the drive status word packer:
 * status bit positions, reset values, torque word scaling and the
 * condition and speed bundles that feed the packer.
 * Assumes a single clock domain and a synchronous active-high reset.
 */
package dswp_pkg;

  // ===========================================================================
  // Word widths and slots
  // ===========================================================================
  localparam int STATUS_W = 16;
  localparam int WORD_W = 16;
  localparam logic [4:0] TORQUE_SLOT = 5'h17;

  // ===========================================================================
  // Status bit positions
  // ===========================================================================
  localparam int BIT_READY_SWITCH_ON = 0;
  localparam int BIT_READY = 1;
  localparam int BIT_OPERATION_ENABLED = 2;
  localparam int BIT_FAULT = 3;
  localparam int BIT_NO_COAST_STOP = 4;
  localparam int BIT_NO_QUICK_STOP = 5;
  localparam int BIT_POWER_ON_INHIBIT = 6;
  localparam int BIT_ALARM = 7;
  localparam int BIT_SPEED_IN_TOL = 8;
  localparam int BIT_CONTROL_REQUEST = 9;
  localparam int BIT_COMPARE_REACHED = 10;
  localparam int BIT_LIMIT_REACHED = 11;
  localparam int BIT_BRAKE_OPEN = 12;
  localparam int BIT_MOTOR_OVERTEMP = 13;
  localparam int BIT_SPEED_NON_NEG = 14;
  localparam int BIT_CONVERTER_OVERLOAD = 15;

  // ===========================================================================
  // Reset values and scaling
  // ===========================================================================
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [15:0] TORQUE_RESET = 16'h0000;
  localparam int NORM_SHIFT = 14;
  localparam logic [15:0] TORQUE_SAT_POS = 16'h7fff;
  localparam logic [15:0] TORQUE_SAT_NEG = 16'h8000;
  localparam int DIV_W = 32;
  localparam int DIV_STEPS = 32;

  // ===========================================================================
  // Types
  // ===========================================================================
  typedef enum logic [2:0] {
    DS_INIT,
    DS_INHIBIT,
    DS_READY_ON,
    DS_SWITCHED_ON,
    DS_OPERATION,
    DS_FAULT
  } dswp_drive_state_t;

  typedef struct packed {
    logic supply_on;
    logic electronics_ready;
    logic line_voltage;
    logic pulses_enabled;
    logic at_setpoint;
    logic fault_active;
    logic fault_ack;
    logic coast_stop_request;
    logic quick_stop_request;
    logic normal_stop_command;
    logic switch_on_command;
    logic alarm_pending;
    logic control_request;
    logic limit_reached;
    logic brake_open_command;
    logic motor_overtemp_alarm;
    logic converter_overload_alarm;
  } dswp_cond_t;

  typedef struct packed {
    logic signed [15:0] setpoint;
    logic signed [15:0] actual;
    logic [15:0] tolerance;
    logic [15:0] compare_level;
  } dswp_speed_t;

endpackage

// ---- hdl/dswp_divider.sv ----
/*
 * Unsigned restoring divider, one quotient bit per clock.
 * Assumes start is only honoured while idle; the quotient stays valid
 * from the done pulse until the next start.
 */
`timescale 1ns/1ps
module dswp_divider #(
  parameter int W = 32,
  parameter int STEPS = 32
) (
  input wire logic clk, // Clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic start, // Start pulse, taken while idle.
  input wire logic [W-1:0] dividend, // Dividend at start.
  input wire logic [W-1:0] divisor, // Divisor at start.
  output logic busy, // High while dividing.
  output logic done, // One-cycle pulse when quotient is ready.
  output logic [W-1:0] quotient // Result, held until next start.
);
  import dswp_pkg::*;

  localparam int CW = $clog2(STEPS + 1);

  typedef struct packed {
    logic [CW-1:0] count;
    logic [W:0] rem;
    logic [W-1:0] quo;
    logic [W-1:0] div;
    logic busy;
    logic done;
  } dswp_div_state_t;

  dswp_div_state_t s;
  dswp_div_state_t next_s;

  // ===========================================================================
  // Step logic
  // ===========================================================================
  always_comb begin
    logic [W:0] trial;
    trial = '0;
    next_s = s;
    next_s.done = 1'b0;
    if (s.busy) begin
      trial = {s.rem[W-1:0], s.quo[W-1]};
      next_s.quo = {s.quo[W-2:0], 1'b0};
      if (trial >= {1'b0, s.div}) begin
        next_s.rem = trial - {1'b0, s.div};
        next_s.quo[0] = 1'b1;
      end else begin
        next_s.rem = trial;
      end
      next_s.count = s.count - CW'(1);
      if (s.count == CW'(1)) begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
      end
    end else if (start) begin
      next_s.rem = '0;
      next_s.quo = dividend;
      next_s.div = divisor;
      next_s.count = CW'(STEPS);
      next_s.busy = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign busy = s.busy;
  assign done = s.done;
  assign quotient = s.quo;

endmodule // dswp_divider

// ---- tb/dswp_packer_properties.sv ----
/* Checker of the status and torque words.
   Assumes it is bound into dswp_packer. */
`timescale 1ns/1ps
module dswp_checker (
  input wire logic MCLK, // Clock.
  input wire logic SYS_RST, // Reset.
  input wire logic CYCLE_TICK, // Cycle strobe.
  input wire dswp_pkg::dswp_cond_t DRIVE_COND, // Conditions.
  input wire dswp_pkg::dswp_speed_t SPEED, // Speeds.
  input wire logic [15:0] STATUS_WORD, // Status word.
  input wire logic STATUS_VALID, // Status pulse.
  input wire logic [4:0] TORQUE_WORD_SLOT, // Slot.
  input wire logic TORQUE_VALID // Torque pulse.
);
  import dswp_pkg::*;
  dswp_cond_t c;
  logic [15:0] w;
  assign c = DRIVE_COND;
  assign w = STATUS_WORD;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  // ========
  // Status word
  a_valid_tick: assert property (1 |=> STATUS_VALID == $past(CYCLE_TICK))
    else $error("status pulse not one cycle after tick");
  a_word_hold: assert property (!CYCLE_TICK |=> $stable(w))
    else $error("status word changed without tick");
  a_ready_bit: assert property (CYCLE_TICK |=> w[0] == $past(c.supply_on & c.electronics_ready))
    else $error("ready bit wrong");
  a_line_bit: assert property (CYCLE_TICK |=> w[1] == $past(c.line_voltage))
    else $error("line bit wrong");
  a_op_needs: assert property (CYCLE_TICK ##1 w[2] |-> $past(c.pulses_enabled & c.at_setpoint))
    else $error("operation bit without pulses");
  a_fault_excl: assert property (STATUS_VALID |-> !(w[3] && w[6]))
    else $error("fault and inhibit together");
  a_stop_bits: assert property (CYCLE_TICK |=> w[5:4] == ~$past({c.quick_stop_request,
    c.coast_stop_request}))
    else $error("stop bits not inverted");
  a_flag_bits: assert property (CYCLE_TICK |=> {w[15], w[13:11], w[9], w[7]} == $past({
    c.converter_overload_alarm, c.motor_overtemp_alarm, c.brake_open_command, c.limit_reached,
    c.control_request, c.alarm_pending}))
    else $error("flag bits wrong");
  a_sign_bit: assert property (CYCLE_TICK |=> w[14] == !$past(SPEED.actual[15]))
    else $error("sign bit wrong");
  // ========
  // Torque word
  a_slot_fixed: assert property (TORQUE_WORD_SLOT == TORQUE_SLOT)
    else $error("torque slot wrong");
  a_torque_lat: assert property (TORQUE_VALID |-> $past(CYCLE_TICK, 35))
    else $error("torque word late or early");
  c_op: cover property (CYCLE_TICK ##1 w[2]);
  c_fault: cover property (STATUS_VALID && w[3]);
  c_torque: cover property (TORQUE_VALID);
endmodule // dswp_checker

bind dswp_packer dswp_checker u_chk (.MCLK, .SYS_RST, .CYCLE_TICK, .DRIVE_COND, .SPEED,
  .STATUS_WORD, .STATUS_VALID, .TORQUE_WORD_SLOT, .TORQUE_VALID);

// ---- tb/dswp_ctrl_model.sv ----
/* Motion controller model: strobes each cycle and keeps the words it reads.
   Assumes one clock shared with the packer. */
`timescale 1ns/1ps
module dswp_ctrl_model #(
  parameter int PERIOD = 40
) (
  input wire logic clk, // Clock.
  input wire logic rst, // Reset.
  input wire logic [15:0] status, // Status word.
  input wire logic st_valid, // Status pulse.
  input wire logic [15:0] torque, // Torque word.
  input wire logic tq_valid, // Torque pulse.
  output logic tick, // Cycle strobe.
  output logic [15:0] seen_status, // Last status read.
  output logic [15:0] seen_torque, // Last torque read.
  output int n_status, // Status reads.
  output int n_torque // Torque reads.
);
  int cnt;
  // Words stand in the same cycle as their pulse, so they are read on it.
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= 0;
      tick <= 1'b0;
      n_status <= 0;
      n_torque <= 0;
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      tick <= (cnt == 0);
      if (st_valid) begin
        seen_status <= status;
        n_status <= n_status + 1;
      end
      if (tq_valid) begin
        seen_torque <= torque;
        n_torque <= n_torque + 1;
      end
    end
  end
endmodule // dswp_ctrl_model

// ---- tb/dswp_packer_tb.sv ----
/* Testbench of the drive status word packer.
   Assumes the controller model strobes every 40 clocks. */
`timescale 1ns/1ps
module dswp_packer_tb;
  import dswp_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  dswp_cond_t cond;
  dswp_speed_t spd;
  logic [15:0] tq, tref, sw, tw, ss, st;
  logic sv, tv, tick;
  logic [4:0] slot;
  int ns, nt;
  int num_errors = 0;
  int checks = 0;
  always #12.5 clk = ~clk;
  dswp_packer DUT (.MCLK(clk), .SYS_RST(rst), .CYCLE_TICK(tick), .DRIVE_COND(cond),
    .SPEED(spd), .TORQUE_SETPOINT(tq), .TORQUE_REFERENCE_QUANTITY(tref), .STATUS_WORD(sw),
    .STATUS_VALID(sv), .TORQUE_SETPOINT_WORD(tw), .TORQUE_WORD_SLOT(slot), .TORQUE_VALID(tv));
  dswp_ctrl_model u_ctrl (.clk(clk), .rst(rst), .status(sw), .st_valid(sv), .torque(tw),
    .tq_valid(tv), .tick(tick), .seen_status(ss), .seen_torque(st), .n_status(ns),
    .n_torque(nt));
  // ========
  // Helpers
  task automatic give_verdict();
    if (num_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Two reads, so the second surely sampled the new inputs.
  task automatic wt(input bit sel);
    int n0;
    int k;
    n0 = sel ? nt : ns;
    k = 0;
    while ((sel ? nt : ns) < n0 + 2 && k < 200) begin
      @(posedge clk);
      k++;
    end
    if (k == 200) begin
      num_errors++;
      give_verdict();
    end
  endtask
  function automatic logic [15:0] ew(input logic op, input logic flt, input logic inh);
    int a;
    int d;
    logic [15:0] w;
    a = $signed(spd.actual);
    d = $signed(spd.setpoint) - a;
    w[14] = a >= 0;
    a = (a < 0) ? -a : a;
    d = (d < 0) ? -d : d;
    w[0] = cond.supply_on & cond.electronics_ready;
    w[1] = cond.line_voltage;
    w[2] = op & cond.electronics_ready & cond.pulses_enabled & cond.at_setpoint;
    w[3] = flt;
    w[4] = ~cond.coast_stop_request;
    w[5] = ~cond.quick_stop_request;
    w[6] = inh;
    w[7] = cond.alarm_pending;
    w[8] = d <= int'(spd.tolerance);
    w[9] = cond.control_request;
    w[10] = a >= int'(spd.compare_level);
    w[11] = cond.limit_reached;
    w[12] = cond.brake_open_command;
    w[13] = cond.motor_overtemp_alarm;
    w[15] = cond.converter_overload_alarm;
    return w;
  endfunction
  function automatic logic [15:0] et(input logic [15:0] t, input logic [15:0] r);
    longint m;
    longint q;
    logic n;
    m = $signed(t);
    n = m < 0;
    m = n ? -m : m;
    q = (r == 16'h0000) ? 40000 : m * 16384 / r;
    if (q > (n ? 32768 : 32767)) q = n ? 32768 : 32767;
    return n ? 16'(-q) : 16'(q);
  endfunction
  // ========
  // Scenarios
  task automatic s_power_up();
    @(posedge clk);
    cond.supply_on <= 1'b1;
    cond.electronics_ready <= 1'b1;
    cond.line_voltage <= 1'b1;
    spd <= {16'h0000, 16'hfffb, 16'h0005, 16'h0005};
    wt(0);
    chk(ss, ew(0, 0, 1));
  endtask
  task automatic s_restart();
    @(posedge clk);
    cond.normal_stop_command <= 1'b1;
    wt(0);
    chk(ss, ew(0, 0, 0));
    cond.normal_stop_command <= 1'b0;
    cond.switch_on_command <= 1'b1;
    spd <= {16'h0010, 16'h0020, 16'h000f, 16'h0021};
    wt(0);
    chk(ss, ew(0, 0, 0));
    cond.pulses_enabled <= 1'b1;
    cond.at_setpoint <= 1'b1;
    {cond.alarm_pending, cond.control_request, cond.limit_reached} <= 3'h7;
    {cond.brake_open_command, cond.motor_overtemp_alarm} <= 2'h3;
    cond.converter_overload_alarm <= 1'b1;
    wt(0);
    chk(ss, ew(1, 0, 0));
  endtask
  task automatic s_fault();
    cond.fault_active <= 1'b1;
    wt(0);
    chk(ss, ew(0, 1, 0));
    cond.fault_active <= 1'b0;
    wt(0);
    chk(ss, ew(0, 1, 0));
    cond.fault_ack <= 1'b1;
    wt(0);
    chk(ss, ew(0, 0, 1));
    cond.fault_ack <= 1'b0;
  endtask
  task automatic s_stops();
    cond.coast_stop_request <= 1'b1;
    cond.quick_stop_request <= 1'b1;
    cond.normal_stop_command <= 1'b1;
    wt(0);
    chk(ss, ew(0, 0, 1));
    cond.coast_stop_request <= 1'b0;
    cond.quick_stop_request <= 1'b0;
    wt(0);
    chk(ss, ew(0, 0, 0));
    cond.coast_stop_request <= 1'b1;
    cond.normal_stop_command <= 1'b0;
    wt(0);
    chk(ss, ew(0, 0, 1));
    cond.coast_stop_request <= 1'b0;
  endtask
  task automatic s_torque();
    logic [15:0] tv_in [5] = '{16'h1000, 16'he000, 16'h7fff, 16'h8001, 16'h0003};
    logic [15:0] rv_in [5] = '{16'h4000, 16'h4000, 16'h0100, 16'h0000, 16'h0007};
    for (int i = 0; i < 5; i++) begin
      tq <= tv_in[i];
      tref <= rv_in[i];
      wt(1);
      chk(st, et(tv_in[i], rv_in[i]));
    end
  endtask
  task automatic s_reset();
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    chk(sw, 16'h0000);
    chk({11'h000, slot}, {11'h000, TORQUE_SLOT});
    rst <= 1'b0;
    wt(0);
    chk(ss, ew(0, 0, 1));
  endtask
  initial begin
    cond = '0;
    spd = '0;
    tq = 16'h0000;
    tref = 16'h4000;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    s_power_up();
    s_restart();
    s_fault();
    s_stops();
    s_torque();
    s_reset();
    give_verdict();
  end
endmodule // dswp_packer_tb
